// ---- logic/tss_pkg.sv ----
// constants for the special transmit symbol block
package tss_pkg;
   localparam logic [7:0] ADDR_RATE      = 8'h4C;
   localparam logic [7:0] ADDR_S0_HIGH   = 8'h4D;
   localparam logic [7:0] ADDR_S0_LOW    = 8'h4E;
   localparam logic [7:0] ADDR_S1_HIGH   = 8'h4F;
   localparam logic [7:0] ADDR_S1_LOW    = 8'h50;
   localparam logic [7:0] ADDR_S2        = 8'h51;
   localparam logic [7:0] ADDR_S3        = 8'h52;
   localparam logic [7:0] ADDR_LEN_LOWER = 8'h53;
   localparam logic [7:0] ADDR_LEN_UPPER = 8'h54;
   localparam logic [7:0] ADDR_BURST     = 8'h55;
   localparam logic [7:0] ADDR_ENVELOPE  = 8'h56;
   localparam logic [7:0] RESET_VALUE    = 8'h00;
   localparam logic [7:0] MASK_LEN_UPPER = 8'h77;
   localparam logic [7:0] MASK_BURST     = 8'h77;
   localparam logic [7:0] MASK_ENVELOPE  = 8'h7F;
   localparam int         UPPER_SC_BIT   = 7;
   localparam int         UPPER_RATE_LSB = 4;
   localparam int         LOWER_SC_BIT   = 3;
   localparam int         LOWER_RATE_LSB = 0;
   localparam int         S1_LEVEL_BIT   = 6;
   localparam int         S1_ALONE_BIT   = 5;
   localparam int         S1_ENABLE_BIT  = 4;
   localparam int         S0_LEVEL_BIT   = 2;
   localparam int         S0_ALONE_BIT   = 1;
   localparam int         S0_ENABLE_BIT  = 0;
   // rate codes 000b and 001b are reserved
   localparam logic [2:0] RATE_FIRST_LEGAL = 3'h2;
   localparam logic [2:0] ENV_FIRST_RFU    = 3'h6;
   // bit period in core cycles at 40 MHz, index = rate code
   localparam int CORE_HZ = 40_000_000;
   localparam logic [10:0] RATE_CYCLES [8] = '{
      11'h5F5, 11'h5F5, 11'h5F5, 11'h2FA, 11'h17A, 11'h0BD, 11'h05E, 11'h02F};
   typedef enum logic [3:0] {
      TSS_IDLE  = 4'b0001,
      TSS_BURST = 4'b0010,
      TSS_DATA  = 4'b0100,
      TSS_DONE  = 4'b1000
   } tss_state_e;
endpackage : tss_pkg

// ---- logic/tss_bit_timer.sv ----
// bit-period tick generator for the symbol shifter
`timescale 1ns/1ps
`default_nettype none
module tss_bit_timer (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clkEn,
   input  wire logic        restart,
   input  wire logic [10:0] period,
   output logic             tick
);
   logic [10:0] count;
   wire         atEnd = (count >= period - 11'h001);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= 11'h000;
         tick  <= 1'b0;
      end else if (clkEn) begin
         count <= (restart || atEnd) ? 11'h000 : count + 11'h001;
         tick  <= atEnd && !restart;
      end
   end
endmodule : tss_bit_timer
`default_nettype wire

// ---- logic/tx_special_symbol_config.sv ----
// special transmit symbol registers and symbol shifter
// Operation
// - rate bit 7 picks upper pair subcarrier, 0=424 kHz, 1=848 kHz
// - rate bits 6:4 pick upper pair bit rate; 000b, 001b reserved
// - rate bit 3 picks lower pair subcarrier, 0=424 kHz, 1=848 kHz
// - rate bits 2:0 pick lower pair bit rate, same coding
// - symbol zero pattern is 4Dh upper byte and 4Eh lower byte
// - symbol one pattern is 4Fh upper byte and 50h lower byte
// - symbol two pattern is the byte at 51h
// - symbol three pattern is the byte at 52h
// - 53h bits 7:4 give symbol one valid bits minus one
// - 53h bits 3:0 give symbol zero valid bits minus one
// - 54h bits 6:4 give symbol three valid bits minus one
// - 54h bits 2:0 give symbol two valid bits minus one
// - 55h bit 6 sets symbol one burst level
// - 55h bit 5 sends symbol one as burst without pattern
// - 55h bit 4 adds a burst to symbol one
// - 55h bit 2 sets symbol zero burst level
// - 55h bit 1 sends symbol zero as burst without pattern
// - 55h bit 0 adds a burst to symbol zero
// - 56h bits 2:0 envelope for symbols zero and one; 6h, 7h reserved
`timescale 1ns/1ps
`default_nettype none
module tx_special_symbol_config (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       clkEn,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       symStart,
   input  wire logic [1:0] symSelect,
   input  wire logic [7:0] lower_pair_burst_length,
   output logic            symBusy,
   output logic            symData,
   output logic            symBurst,
   output logic            symDone,
   output logic            subcarrierHigh,
   output logic      [2:0] envelopeSelect,
   output logic            rateReserved
);
   logic [7:0] symbol_rate_select;
   logic [7:0] sym_zero_pattern_high;
   logic [7:0] sym_zero_pattern_low;
   logic [7:0] sym_one_pattern_high;
   logic [7:0] sym_one_pattern_low;
   logic [7:0] sym_two_pattern;
   logic [7:0] sym_three_pattern;
   logic [7:0] sym_lower_pair_lengths;
   logic [7:0] sym_upper_pair_lengths;
   logic [7:0] sym_lower_pair_burst_ctrl;
   logic [7:0] envelopeReg;

   tss_pkg::tss_state_e state;
   logic [15:0] shiftPattern;
   logic [4:0]  bitsLeft;
   logic [7:0]  burstLeft;
   logic [1:0]  activeSym;
   logic        burstLevel;
   logic        timerRestart;
   wire         bitTick;

   // decoded fields
   wire       upper_pair_subcarrier_rate = symbol_rate_select[tss_pkg::UPPER_SC_BIT];
   wire [2:0] upper_pair_bit_rate =
      symbol_rate_select[tss_pkg::UPPER_RATE_LSB +: 3];
   wire       lower_pair_subcarrier_rate = symbol_rate_select[tss_pkg::LOWER_SC_BIT];
   wire [2:0] lower_pair_bit_rate =
      symbol_rate_select[tss_pkg::LOWER_RATE_LSB +: 3];
   wire [15:0] symZeroPattern = {sym_zero_pattern_high, sym_zero_pattern_low};
   wire [15:0] symOnePattern  = {sym_one_pattern_high, sym_one_pattern_low};
   wire [3:0] sym_one_valid_bits   = sym_lower_pair_lengths[7:4];
   wire [3:0] sym_zero_valid_bits  = sym_lower_pair_lengths[3:0];
   wire [2:0] sym_three_valid_bits = sym_upper_pair_lengths[6:4];
   wire [2:0] sym_two_valid_bits   = sym_upper_pair_lengths[2:0];
   wire sym_one_burst_level   = sym_lower_pair_burst_ctrl[tss_pkg::S1_LEVEL_BIT];
   wire sym_one_burst_alone   = sym_lower_pair_burst_ctrl[tss_pkg::S1_ALONE_BIT];
   wire sym_one_burst_enable  = sym_lower_pair_burst_ctrl[tss_pkg::S1_ENABLE_BIT];
   wire sym_zero_burst_level  = sym_lower_pair_burst_ctrl[tss_pkg::S0_LEVEL_BIT];
   wire sym_zero_burst_alone  = sym_lower_pair_burst_ctrl[tss_pkg::S0_ALONE_BIT];
   wire sym_zero_burst_enable = sym_lower_pair_burst_ctrl[tss_pkg::S0_ENABLE_BIT];
   wire [2:0] lower_pair_envelope_select = envelopeReg[2:0];

   function automatic logic rateIsReserved(input logic [2:0] code);
      rateIsReserved = (code < tss_pkg::RATE_FIRST_LEGAL);
   endfunction

   // per-symbol selection for a new start
   wire        upperPair = symSelect[1];
   wire [15:0] startPattern =
      (symSelect == 2'd0) ? symZeroPattern :
      (symSelect == 2'd1) ? symOnePattern  :
      (symSelect == 2'd2) ? {sym_two_pattern, 8'h00} : {sym_three_pattern, 8'h00};
   wire [3:0]  startLenCode =
      (symSelect == 2'd0) ? sym_zero_valid_bits :
      (symSelect == 2'd1) ? sym_one_valid_bits  :
      (symSelect == 2'd2) ? {1'b0, sym_two_valid_bits} : {1'b0, sym_three_valid_bits};
   wire [4:0]  startBits = {1'b0, startLenCode} + 5'd1;
   // left-align so the top valid bit goes out first
   wire [15:0] alignedPattern = upperPair ?
      (startPattern << (5'd8 - startBits)) : (startPattern << (5'd16 - startBits));
   wire startBurstEn = (symSelect == 2'd0) ? sym_zero_burst_enable :
                       (symSelect == 2'd1) ? sym_one_burst_enable : 1'b0;
   wire startAlone   = (symSelect == 2'd0) ? sym_zero_burst_alone :
                       (symSelect == 2'd1) ? sym_one_burst_alone : 1'b0;
   wire startLevel   = (symSelect == 2'd0) ? sym_zero_burst_level : sym_one_burst_level;
   // burst-alone with no length still emits nothing but a done
   wire doBurst      = (startBurstEn || startAlone) && (lower_pair_burst_length != 8'h00);
   wire [2:0] activeRate = activeSym[1] ? upper_pair_bit_rate : lower_pair_bit_rate;
   wire [2:0] pickRate   = upperPair ? upper_pair_bit_rate : lower_pair_bit_rate;
   wire [10:0] bitPeriod = tss_pkg::RATE_CYCLES[activeRate];

   wire [7:0] readMux =
      (regAddr == tss_pkg::ADDR_RATE)      ? symbol_rate_select :
      (regAddr == tss_pkg::ADDR_S0_HIGH)   ? sym_zero_pattern_high :
      (regAddr == tss_pkg::ADDR_S0_LOW)    ? sym_zero_pattern_low :
      (regAddr == tss_pkg::ADDR_S1_HIGH)   ? sym_one_pattern_high :
      (regAddr == tss_pkg::ADDR_S1_LOW)    ? sym_one_pattern_low :
      (regAddr == tss_pkg::ADDR_S2)        ? sym_two_pattern :
      (regAddr == tss_pkg::ADDR_S3)        ? sym_three_pattern :
      (regAddr == tss_pkg::ADDR_LEN_LOWER) ? sym_lower_pair_lengths :
      (regAddr == tss_pkg::ADDR_LEN_UPPER) ? sym_upper_pair_lengths :
      (regAddr == tss_pkg::ADDR_BURST)     ? sym_lower_pair_burst_ctrl :
      (regAddr == tss_pkg::ADDR_ENVELOPE)  ? envelopeReg : 8'h00;

   tss_bit_timer i_tss_bit_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clkEn    (clkEn),
      .restart  (timerRestart),
      .period   (bitPeriod),
      .tick     (bitTick)
   );

   // register writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         symbol_rate_select        <= tss_pkg::RESET_VALUE;
         sym_zero_pattern_high     <= tss_pkg::RESET_VALUE;
         sym_zero_pattern_low      <= tss_pkg::RESET_VALUE;
         sym_one_pattern_high      <= tss_pkg::RESET_VALUE;
         sym_one_pattern_low       <= tss_pkg::RESET_VALUE;
         sym_two_pattern           <= tss_pkg::RESET_VALUE;
         sym_three_pattern         <= tss_pkg::RESET_VALUE;
         sym_lower_pair_lengths    <= tss_pkg::RESET_VALUE;
         sym_upper_pair_lengths    <= tss_pkg::RESET_VALUE;
         sym_lower_pair_burst_ctrl <= tss_pkg::RESET_VALUE;
         envelopeReg               <= tss_pkg::RESET_VALUE;
      end else if (clkEn && regWrite) begin
         unique case (regAddr)
            tss_pkg::ADDR_RATE:      symbol_rate_select <= regWdata;
            tss_pkg::ADDR_S0_HIGH:   sym_zero_pattern_high <= regWdata;
            tss_pkg::ADDR_S0_LOW:    sym_zero_pattern_low <= regWdata;
            tss_pkg::ADDR_S1_HIGH:   sym_one_pattern_high <= regWdata;
            tss_pkg::ADDR_S1_LOW:    sym_one_pattern_low <= regWdata;
            tss_pkg::ADDR_S2:        sym_two_pattern <= regWdata;
            tss_pkg::ADDR_S3:        sym_three_pattern <= regWdata;
            tss_pkg::ADDR_LEN_LOWER: sym_lower_pair_lengths <= regWdata;
            tss_pkg::ADDR_LEN_UPPER:
               sym_upper_pair_lengths <= regWdata & tss_pkg::MASK_LEN_UPPER;
            tss_pkg::ADDR_BURST:
               sym_lower_pair_burst_ctrl <= regWdata & tss_pkg::MASK_BURST;
            tss_pkg::ADDR_ENVELOPE:  envelopeReg <= regWdata & tss_pkg::MASK_ENVELOPE;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
      end else if (clkEn && regRead) begin
         regRdata <= readMux;
      end
   end

   // symbol sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state        <= tss_pkg::TSS_IDLE;
         shiftPattern <= 16'h0000;
         bitsLeft     <= 5'd0;
         burstLeft    <= 8'h00;
         activeSym    <= 2'd0;
         burstLevel   <= 1'b0;
         timerRestart <= 1'b1;
         symBusy      <= 1'b0;
         symData      <= 1'b0;
         symBurst     <= 1'b0;
         symDone      <= 1'b0;
      end else if (clkEn) begin
         symDone      <= 1'b0;
         timerRestart <= 1'b0;
         unique case (state)
            tss_pkg::TSS_IDLE: begin
               timerRestart <= 1'b1;
               // reserved rate code: start refused, symbol not sent
               if (symStart && !rateIsReserved(pickRate)) begin
                  activeSym    <= symSelect;
                  shiftPattern <= alignedPattern;
                  bitsLeft     <= startAlone ? 5'd0 : startBits;
                  burstLeft    <= lower_pair_burst_length;
                  burstLevel   <= startLevel;
                  symBusy      <= 1'b1;
                  timerRestart <= 1'b0;
                  if (doBurst) begin
                     state    <= tss_pkg::TSS_BURST;
                     symBurst <= 1'b1;
                     symData  <= startLevel;
                  end else if (!startAlone) begin
                     state   <= tss_pkg::TSS_DATA;
                     symData <= alignedPattern[15];
                  end else begin
                     state <= tss_pkg::TSS_DONE;
                  end
               end
            end
            tss_pkg::TSS_BURST: begin
               symData <= burstLevel;
               if (bitTick) begin
                  burstLeft <= burstLeft - 8'h01;
                  if (burstLeft == 8'h01) begin
                     symBurst <= 1'b0;
                     if (bitsLeft == 5'd0) begin
                        state <= tss_pkg::TSS_DONE;
                     end else begin
                        state   <= tss_pkg::TSS_DATA;
                        symData <= shiftPattern[15];
                     end
                  end
               end
            end
            tss_pkg::TSS_DATA: begin
               if (bitTick) begin
                  bitsLeft     <= bitsLeft - 5'd1;
                  shiftPattern <= {shiftPattern[14:0], 1'b0};
                  symData      <= shiftPattern[14];
                  if (bitsLeft == 5'd1) begin
                     state <= tss_pkg::TSS_DONE;
                  end
               end
            end
            tss_pkg::TSS_DONE: begin
               state   <= tss_pkg::TSS_IDLE;
               symBusy <= 1'b0;
               symData <= 1'b0;
               symDone <= 1'b1;
            end
            default: state <= tss_pkg::TSS_IDLE;
         endcase
      end
   end

   // modulator settings for the symbol in flight
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         subcarrierHigh <= 1'b0;
         envelopeSelect <= 3'h0;
         rateReserved   <= 1'b0;
      end else if (clkEn) begin
         subcarrierHigh <= activeSym[1] ? upper_pair_subcarrier_rate
                                        : lower_pair_subcarrier_rate;
         // reserved envelope codes fall back to direct output
         envelopeSelect <= (lower_pair_envelope_select >= tss_pkg::ENV_FIRST_RFU) ?
                           3'h0 : lower_pair_envelope_select;
         rateReserved   <= rateIsReserved(activeRate);
      end
   end
endmodule : tx_special_symbol_config
`default_nettype wire

// ---- testbench/tx_special_symbol_config_assertions.sv ----
// concurrent port checks for the special transmit symbol block
`timescale 1ns/1ps
`default_nettype none
module tss_checker (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       clkEn,
   input wire logic       regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdata,
   input wire logic       symStart,
   input wire logic       symBusy,
   input wire logic       symData,
   input wire logic       symBurst,
   input wire logic       symDone,
   input wire logic [2:0] envelopeSelect
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence sDoneRun;
      symDone && clkEn;
   endsequence
   sequence sLaunch;
      $rose(symBusy);
   endsequence
   sequence sReadTaken;
      regRead && clkEn;
   endsequence
   done_pulse_a: assert property (sDoneRun |=> !symDone)
      else $error("done pulse longer than one cycle");
   done_idle_a: assert property (symDone |-> !symBusy)
      else $error("busy still high at done");
   launch_cause_a: assert property (sLaunch |-> $past(symStart) && $past(clkEn))
      else $error("symbol began without a start");
   burst_busy_a: assert property (symBurst |-> symBusy)
      else $error("burst outside a symbol");
   unmapped_read_a: assert property (sReadTaken ##0 (regAddr < 8'h4C || regAddr > 8'h56)
      |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   reserved_read_a: assert property (sReadTaken ##0 (regAddr == 8'h54 || regAddr == 8'h55)
      |=> !regRdata[7] && !regRdata[3])
      else $error("reserved bit read as one");
   rdata_hold_a: assert property (!(regRead && clkEn) |=> $stable(regRdata))
      else $error("read data changed without a read");
   freeze_state_a: assert property (!clkEn |=> $stable(symBusy) && $stable(symData))
      else $error("state moved while clock enable low");
   envelope_legal_a: assert property (envelopeSelect < 3'h6)
      else $error("reserved envelope code shown");
endmodule // tss_checker
bind tx_special_symbol_config tss_checker i_tss_checker (
   .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regRead(regRead),
   .regAddr(regAddr), .regRdata(regRdata), .symStart(symStart), .symBusy(symBusy),
   .symData(symData), .symBurst(symBurst), .symDone(symDone),
   .envelopeSelect(envelopeSelect));
`default_nettype wire

// ---- testbench/test_tx_special_symbol_config.sv ----
// self-checking bench for the special transmit symbol block
`timescale 1ns/1ps
`default_nettype none
module test_tx_special_symbol_config;
   localparam int PERIOD = int'(tss_pkg::RATE_CYCLES[7]);
   logic       core_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clkEn = 1'b1;
   logic       regWrite = 1'b0;
   logic       regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic       symStart = 1'b0;
   logic [1:0] symSelect = 2'h0;
   logic [7:0] burstLen = 8'h00;
   logic [7:0] regRdata;
   logic [2:0] envelopeSelect;
   logic       symBusy, symData, symBurst, symDone, subcarrierHigh, rateReserved;
   int         errCount = 0;
   int         samplesChecked = 0;
   tx_special_symbol_config i_tx_special_symbol_config (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .symStart(symStart), .symSelect(symSelect), .lower_pair_burst_length(burstLen),
      .symBusy(symBusy), .symData(symData), .symBurst(symBurst), .symDone(symDone),
      .subcarrierHigh(subcarrierHigh), .envelopeSelect(envelopeSelect),
      .rateReserved(rateReserved));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errCount++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // strobe dropped for a cycle so back-to-back calls never reassign it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(posedge core_clk);
      #1 chk(regRdata, exp);
   endtask
   // samples each bit period in its middle, burst bits first
   task automatic sendSym(input logic [1:0] sel, input int n, input logic [23:0] dat,
                          input logic [23:0] bst, input logic sc);
      int w;
      symStart <= 1'b1;
      symSelect <= sel;
      @(posedge core_clk);
      symStart <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat ((i == n - 1) ? PERIOD / 2 : PERIOD) @(posedge core_clk);
         #1 chk({6'h00, symBurst, symData}, {6'h00, bst[i], dat[i]});
         chk({5'h00, rateReserved, symBusy, subcarrierHigh}, {5'h00, 1'b0, 1'b1, sc});
      end
      for (w = 0; w < 2 * PERIOD && symDone !== 1'b1; w++) @(posedge core_clk) #1;
      chk({6'h00, symBusy, symDone}, 8'h01);
   endtask
   task automatic wrapUp;
      if (errCount == 0 && samplesChecked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [7:0] mapped(input logic [7:0] a);
      if (a < 8'h4C || a > 8'h56) return 8'h00;
      if (a == 8'h54 || a == 8'h55) return tss_pkg::MASK_BURST;
      if (a == 8'h56) return tss_pkg::MASK_ENVELOPE;
      return 8'hFF;
   endfunction
   initial begin
      repeat (10000) @(posedge core_clk);
      errCount++;
      wrapUp;
   end
   initial begin
      logic [7:0] a;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      for (a = 8'h4C; a != 8'h57; a++) rd(a, tss_pkg::RESET_VALUE);
      for (a = 8'h4B; a != 8'h58; a++) wr(a, 8'hFF);
      for (a = 8'h4B; a != 8'h58; a++) rd(a, mapped(a));
      clkEn <= 1'b0;
      wr(8'h51, 8'h00);
      clkEn <= 1'b1;
      rd(8'h51, 8'hFF);
      wr(8'h56, 8'h05);
      @(posedge core_clk);
      #1 chk({5'h00, envelopeSelect}, 8'h05);
      wr(8'h56, 8'h06);
      @(posedge core_clk);
      #1 chk({5'h00, envelopeSelect}, 8'h00);
      // upper pair legal and fast, lower pair on a reserved rate
      wr(8'h4C, 8'hF0);
      wr(8'h51, 8'hA5);
      wr(8'h52, 8'h3C);
      wr(8'h54, 8'h71);
      symStart <= 1'b1;
      symSelect <= 2'h0;
      @(posedge core_clk);
      symStart <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk({6'h00, symBusy, rateReserved}, 8'h01);
      sendSym(2'h2, 2, 24'h000001, 24'h000000, 1'b1);
      sendSym(2'h3, 8, 24'h00003C, 24'h000000, 1'b1);
      @(posedge core_clk);
      wr(8'h4C, 8'h07);
      wr(8'h4D, 8'h12);
      wr(8'h4E, 8'h34);
      wr(8'h4F, 8'hC3);
      wr(8'h50, 8'h5A);
      wr(8'h53, 8'hF3);
      wr(8'h55, 8'h65);
      burstLen <= 8'h02;
      sendSym(2'h0, 6, 24'h000034, 24'h000030, 1'b0);
      sendSym(2'h1, 2, 24'h000003, 24'h000003, 1'b0);
      @(posedge core_clk);
      wr(8'h55, 8'h13);
      sendSym(2'h1, 18, 24'h00C35A, 24'h030000, 1'b0);
      @(posedge core_clk);
      sendSym(2'h0, 2, 24'h000000, 24'h000003, 1'b0);
      wrapUp;
   end
endmodule // test_tx_special_symbol_config
`default_nettype wire
